//--- dv/drive_reference_combiner_warnings_tb_top.sv
// self-checking bench for the reference combiner and warning block
`timescale 1ns/1ps
module drive_reference_combiner_warnings_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] analog_ref = 32'h0;
  logic [31:0] pulse_ref = 32'h0;
  logic [31:0] serial_ref = 32'h0;
  logic [1:0] din_preset_sel = 2'h0;
  logic din_use_preset = 1'b0;
  logic din_catch_up = 1'b0;
  logic din_slow_down = 1'b0;
  logic run_cmd = 1'b0;
  logic [31:0] out_freq;
  logic [31:0] out_current = 32'h0;
  logic [31:0] result_ref;
  logic [31:0] output_current_ceiling;
  logic warn_signal_out;
  logic warn_relay_out;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int n_checks = 0;
  int k;
  typedef struct {
    logic [1:0] mode;
    logic [1:0] sel;
    logic [31:0] pre;
    logic [31:0] a;
    logic [31:0] p;
    logic [31:0] s;
    logic usep;
    logic cu;
    logic sd;
    logic [31:0] exp;
  } row_t;
  row_t rows [11];
  logic [11:0] ra [8];
  logic [31:0] rv [8];

  ////////////////////////////////////////////////////////////////////////////
  // clock, design and far-side model
  initial begin
    forever #10 pclk = ~pclk;
  end

  ref_combiner #(.W(32)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_ref(analog_ref),
    .pulse_ref(pulse_ref), .serial_ref(serial_ref),
    .din_preset_sel(din_preset_sel), .din_use_preset(din_use_preset),
    .din_catch_up(din_catch_up), .din_slow_down(din_slow_down),
    .run_cmd(run_cmd), .out_freq(out_freq), .out_current(out_current),
    .result_ref(result_ref),
    .output_current_ceiling(output_current_ceiling),
    .warn_signal_out(warn_signal_out), .warn_relay_out(warn_relay_out)
  );

  motor_model #(.STEP(10)) partner (
    .pclk(pclk), .presetn(presetn), .run_cmd(run_cmd),
    .target(result_ref), .out_freq(out_freq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and apb tasks
  task end_of_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ra = '{ref_pkg::OFF_IMAXLIM, ref_pkg::OFF_FREQ_HIGH_THRESHOLD, ref_pkg::OFF_RCEIL,
      ref_pkg::OFF_CHIGH, ref_pkg::OFF_FLOW, ref_pkg::OFF_PRESET0,
      ref_pkg::OFF_CATCH, ref_pkg::OFF_CEIL};
    rv = '{32'h3e80, 32'h528, 32'h1f4, 32'h7fffffff, 32'h0, 32'h0, 32'h0,
      32'h0};
    // mode sel preset analog pulse serial usep cu sd expected
    rows = '{
      '{2'h0, 2'h0, 32'h5dc, 32'h3e80, 32'h0, 32'h0, 0, 0, 0, 32'h5bcc},
      '{2'h0, 2'h1, 32'h0, 32'h3e8, 32'h7d0, 32'hbb8, 0, 0, 0, 32'h1770},
      '{2'h1, 2'h2, 32'h5dc, 32'h3e80, 32'h0, 32'h0, 0, 0, 0, 32'h47e0},
      '{2'h1, 2'h3, 32'hffffec78, 32'h4e20, 32'h0, 32'h0, 0, 0, 0, 32'h2710},
      '{2'h2, 2'h0, 32'h5dc, 32'h3e80, 32'h0, 32'h0, 1, 0, 0, 32'h1d4c},
      '{2'h2, 2'h0, 32'h5dc, 32'h3e80, 32'h0, 32'h0, 0, 0, 0, 32'h3e80},
      '{2'h0, 2'h0, 32'h0, 32'h2710, 32'h0, 32'h0, 0, 1, 0, 32'h2af8},
      '{2'h0, 2'h0, 32'h0, 32'h2710, 32'h0, 32'h0, 0, 0, 1, 32'h2328},
      '{2'h0, 2'h0, 32'h0, 32'h2710, 32'h0, 32'h0, 0, 1, 1, 32'h2710},
      '{2'h0, 2'h0, 32'h0, 32'hea60, 32'h0, 32'h0, 0, 0, 0, 32'hc350},
      '{2'h0, 2'h0, 32'h0, 32'hfffff448, 32'h0, 32'h0, 0, 0, 0, 32'h0}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(output_current_ceiling, 32'h3e80);
    for (int i = 0; i < 8; i++) begin
      rdchk(ra[i], rv[i]);
    end
    // clamping of written values, refused addresses, ceiling output
    wr(ref_pkg::OFF_RCEIL, 32'hc350);
    wr(ref_pkg::OFF_CATCH, 32'h4e20);
    rdchk(ref_pkg::OFF_CATCH, 32'h2710);
    wr(ref_pkg::OFF_CATCH, 32'h3e8);
    wr(ref_pkg::OFF_PRESET0, 32'h4e20);
    rdchk(ref_pkg::OFF_PRESET0, 32'h2710);
    wr(ref_pkg::OFF_PRESET0, 32'hffffb1e0);
    rdchk(ref_pkg::OFF_PRESET0, 32'hffffd8f0);
    wr(ref_pkg::OFF_FLOW, 32'h7d0);
    rdchk(ref_pkg::OFF_FLOW, 32'h528);
    wr(ref_pkg::OFF_FLOW, 32'h0);
    apb(1'b1, 12'h100, 32'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h002, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(ref_pkg::OFF_IMAXLIM, 32'h2ee0);
    repeat (3) @(posedge pclk);
    chk(output_current_ceiling, 32'h2ee0);
    // table of combining cases, floor 0 so the span equals the ceiling
    foreach (rows[i]) begin
      wr(ref_pkg::OFF_CTRL, {30'h0, rows[i].mode});
      wr(ref_pkg::OFF_PRESET0 + {8'h0, rows[i].sel, 2'b00}, rows[i].pre);
      din_preset_sel <= rows[i].sel;
      analog_ref <= rows[i].a;
      pulse_ref <= rows[i].p;
      serial_ref <= rows[i].s;
      din_use_preset <= rows[i].usep;
      din_catch_up <= rows[i].cu;
      din_slow_down <= rows[i].sd;
      repeat (4) @(posedge pclk);
      chk(result_ref, rows[i].exp);
    end
    // serial preset select overrides the input pins, picks preset 3
    wr(ref_pkg::OFF_CTRL, 32'h1c);
    wr(12'h010, 32'h7d0);
    analog_ref <= 32'h0;
    din_preset_sel <= 2'h0;
    repeat (4) @(posedge pclk);
    chk(result_ref, 32'h2710);
    // warnings: suppressed when stopped and ramping, live on reference
    wr(ref_pkg::OFF_CTRL, 32'h0);
    wr(ref_pkg::OFF_PRESET0, 32'h0);
    rdchk(12'h010, 32'h7d0);
    analog_ref <= 32'h3e8;
    out_current <= 32'h32;
    wr(ref_pkg::OFF_CLOW, 32'h64);
    wr(ref_pkg::OFF_CHIGH, 32'h28);
    wr(ref_pkg::OFF_ROUTE, 32'h21);
    repeat (10) @(posedge pclk);
    chk({30'h0, warn_signal_out, warn_relay_out}, 32'h0);
    rdchk(ref_pkg::OFF_STATUS, 32'h0);
    run_cmd <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({30'h0, warn_signal_out, warn_relay_out}, 32'h0);
    k = 0;
    while (warn_signal_out !== 1'b1 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 300) begin
      error_cnt++;
      end_of_test();
    end
    @(posedge pclk);
    chk({30'h0, warn_signal_out, warn_relay_out}, 32'h3);
    rdchk(ref_pkg::OFF_STATUS, 32'h33);
    wr(ref_pkg::OFF_ROUTE, 32'h42);
    wr(ref_pkg::OFF_FLOW, 32'h4b0);
    repeat (6) @(posedge pclk);
    chk({30'h0, warn_signal_out, warn_relay_out}, 32'h3);
    rdchk(ref_pkg::OFF_STATUS, 32'h37);
    run_cmd <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({30'h0, warn_signal_out, warn_relay_out}, 32'h0);
    end_of_test();
  end
endmodule // drive_reference_combiner_warnings_tb_top

//--- dv/motor_model.sv
// behavioural motor stage: output frequency ramps toward the reference
`timescale 1ns/1ps
module motor_model #(
  parameter int STEP = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_cmd,
  input wire logic [31:0] target,
  output logic [31:0] out_freq
);
  logic signed [31:0] diff;

  ////////////////////////////////////////////////////////////////////////////
  // signed distance left to the reference
  assign diff = $signed(target) - $signed(out_freq);

  ////////////////////////////////////////////////////////////////////////////
  // linear ramp; the last step snaps onto the target exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_freq <= 32'h0;
    end else if (!run_cmd) begin
      out_freq <= 32'h0; // coasts straight down, keeps the test short
    end else if (diff <= STEP && diff >= -STEP) begin
      out_freq <= target;
    end else if (diff > 0) begin
      out_freq <= out_freq + STEP;
    end else begin
      out_freq <= out_freq - STEP;
    end
  end
endmodule // motor_model

//--- verilog/preset_mem.sv
// four-entry preset reference store with registered read
`timescale 1ns/1ps
module preset_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata,
  input wire logic [AW-1:0] baddr,
  output logic [31:0] bdata
);
  logic [31:0] mem_r [DEPTH];
  logic [31:0] rdata_nxt;
  logic [31:0] bdata_nxt;

  ////////////////////////////////////////////////////////////////////////
  // read ports
  always_comb begin
    rdata_nxt = mem_r[raddr];
    bdata_nxt = mem_r[baddr];
  end

  // storage, zero percent after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= ref_pkg::RST_PRESET;
      end
      rdata <= '0;
      bdata <= '0;
    end else begin
      if (we) begin
        mem_r[waddr] <= wdata;
      end
      rdata <= rdata_nxt;
      bdata <= bdata_nxt;
    end
  end
endmodule // preset_mem

//--- verilog/ref_combiner.sv
// reference combiner, current ceiling and warning logic with apb slave
// Functional notes
// - sum mode adds preset percent of floor-to-ceiling span to external total
// - relative mode adds preset percent of external total to that total
// - external/preset mode: input picks external or preset percent of span
// - four presets, two-bit select msb lsb from inputs or serial
// - presets are signed hundredths between -100.00 and +100.00, reset 0
// - sum and relative always apply one preset; zero gives no effect
// - external reference is analog plus pulse plus serial reference
// - remote reference is preset plus analog, pulse and serial parts
// - catch-up input raises remote reference by programmed percent
// - slow-down input lowers remote reference by the same percent
// - output current ceiling held as percent of rated, reset 160 percent
// - low-current warning when measured current below its threshold
// - high-current warning when measured current above its threshold
// - warnings suppressed while ramping after start, after stop, stopped
// - warnings enabled once output frequency reaches resulting reference
// - each warning routable to signal output and to relay output
// - low-frequency threshold limited to 0..high threshold, reset 0 Hz
// - low-frequency warning when output frequency below its threshold
// - combined reference never above the programmed ceiling unless the floor is set above it
// - combined reference never below the programmed floor
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module ref_combiner #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] analog_ref,
  input wire logic [W-1:0] pulse_ref,
  input wire logic [W-1:0] serial_ref,
  input wire logic [1:0] din_preset_sel,
  input wire logic din_use_preset,
  input wire logic din_catch_up,
  input wire logic din_slow_down,
  input wire logic run_cmd,
  input wire logic [W-1:0] out_freq,
  input wire logic [W-1:0] out_current,
  output logic [W-1:0] result_ref,
  output logic [W-1:0] output_current_ceiling,
  output logic warn_signal_out,
  output logic warn_relay_out
);
  // register state
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [31:0] catch_r, catch_nxt, imax_r, imax_nxt;
  logic [31:0] clow_r, clow_nxt, chigh_r, chigh_nxt;
  logic [31:0] flow_r, flow_nxt, freq_high_threshold_r, freq_high_threshold_nxt;
  logic [31:0] rfloor_r, rfloor_nxt, rceil_r, rceil_nxt;
  logic [7:0] route_r, route_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  ref_pkg::wgate_t wg_r, wg_nxt;
  logic [W-1:0] result_nxt;
  logic [31:0] preset_rd, preset_val;
  logic [1:0] psel_idx;
  logic wr, rd, pre_we, at_ref, pre_word, pre_wait_r, pre_wait_nxt;
  logic [ref_pkg::NWARN-1:0] warns;
  logic signed [63:0] ext_sum, span, pre_part, remote, adj, total;
  ref_pkg::ref_mode_t mode;

  // high for an aligned word inside the register map
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ref_pkg::OFF_RESULT);
  endfunction

  // clamp a signed hundredths percent to +/-100.00
  function automatic logic [31:0] clamp_pct(input logic [31:0] v);
    if ($signed(v) > $signed(ref_pkg::PCT_FULL)) begin
      clamp_pct = ref_pkg::PCT_FULL;
    end else if ($signed(v) < $signed(ref_pkg::PCT_NEG_FULL)) begin
      clamp_pct = ref_pkg::PCT_NEG_FULL;
    end else begin
      clamp_pct = v;
    end
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // preset reads take one wait state: the store's read port is registered
  assign pre_word = (paddr >= ref_pkg::OFF_PRESET0) &&
    (paddr < ref_pkg::OFF_CATCH) && (paddr[1:0] == 2'h0);
  assign pre_wait_nxt = rd && pre_word && !pre_wait_r;
  assign pready = !pre_wait_nxt;
  assign pre_we = wr && pre_word;
  assign mode = ref_pkg::ref_mode_t'(ctrl_r[ref_pkg::CTRL_MODE_LSB +: 2]);
  // serial select overrides the digital inputs when enabled
  assign psel_idx = ctrl_r[ref_pkg::CTRL_SERSEL] ?
    ctrl_r[ref_pkg::CTRL_SEL_LSB +: 2] : din_preset_sel;

  ////////////////////////////////////////////////////////////////////////
  // preset store: one port for the bus, one for the datapath
  preset_mem #(.DEPTH(4), .AW(2)) u_presets (
    .pclk(pclk),
    .presetn(presetn),
    .we(pre_we),
    .waddr(2'(paddr[3:2] - 2'h1)),
    .wdata(clamp_pct(pwdata)),
    .raddr(2'(paddr[3:2] - 2'h1)),
    .rdata(preset_rd),
    .baddr(psel_idx),
    .bdata(preset_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    catch_nxt = catch_r;
    imax_nxt = imax_r;
    clow_nxt = clow_r;
    chigh_nxt = chigh_r;
    flow_nxt = flow_r;
    freq_high_threshold_nxt = freq_high_threshold_r;
    rfloor_nxt = rfloor_r;
    rceil_nxt = rceil_r;
    route_nxt = route_r;
    if (wr) begin
      case (paddr)
        ref_pkg::OFF_CTRL: ctrl_nxt = pwdata[5:0];
        ref_pkg::OFF_CATCH: begin
          // catch-up/slow-down percent is 0..100.00
          if ($signed(pwdata) < 0) begin
            catch_nxt = '0;
          end else begin
            catch_nxt = clamp_pct(pwdata);
          end
        end
        ref_pkg::OFF_IMAXLIM: imax_nxt = pwdata;
        ref_pkg::OFF_CLOW: clow_nxt = pwdata;
        ref_pkg::OFF_CHIGH: chigh_nxt = pwdata;
        ref_pkg::OFF_FLOW: begin
          // low threshold may not pass the high one
          flow_nxt = (pwdata > freq_high_threshold_r) ? freq_high_threshold_r : pwdata;
        end
        ref_pkg::OFF_FREQ_HIGH_THRESHOLD: begin
          freq_high_threshold_nxt = pwdata;
          if (flow_r > pwdata) begin
            flow_nxt = pwdata;
          end
        end
        ref_pkg::OFF_RFLOOR: rfloor_nxt = pwdata;
        ref_pkg::OFF_RCEIL: rceil_nxt = pwdata;
        ref_pkg::OFF_ROUTE: route_nxt = pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read mux and error answer for unmapped words
  always_comb begin
    prdata_nxt = '0;
    pslverr_nxt = !mapped(paddr);
    case (paddr)
      ref_pkg::OFF_CTRL: prdata_nxt = {26'h0, ctrl_r};
      ref_pkg::OFF_CATCH: prdata_nxt = catch_r;
      ref_pkg::OFF_IMAXLIM: prdata_nxt = imax_r;
      ref_pkg::OFF_CLOW: prdata_nxt = clow_r;
      ref_pkg::OFF_CHIGH: prdata_nxt = chigh_r;
      ref_pkg::OFF_FLOW: prdata_nxt = flow_r;
      ref_pkg::OFF_FREQ_HIGH_THRESHOLD: prdata_nxt = freq_high_threshold_r;
      ref_pkg::OFF_RFLOOR: prdata_nxt = rfloor_r;
      ref_pkg::OFF_RCEIL: prdata_nxt = rceil_r;
      ref_pkg::OFF_ROUTE: prdata_nxt = {24'h0, route_r};
      ref_pkg::OFF_STATUS: prdata_nxt = {26'h0, wg_r, warns};
      ref_pkg::OFF_RESULT: prdata_nxt = 32'(result_ref);
      default: prdata_nxt = '0; // preset words load in the access cycle
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // reference combination in hundredths
  always_comb begin
    ext_sum = 64'($signed(analog_ref)) + 64'($signed(pulse_ref)) +
      64'($signed(serial_ref));
    span = 64'($signed(rceil_r)) - 64'($signed(rfloor_r));
    case (mode)
      ref_pkg::MODE_REL:
        pre_part = (ext_sum * 64'($signed(preset_val))) /
          64'($signed(ref_pkg::PCT_FULL));
      default:
        pre_part = (span * 64'($signed(preset_val))) /
          64'($signed(ref_pkg::PCT_FULL));
    endcase
    if (mode == ref_pkg::MODE_EXT) begin
      remote = din_use_preset ? pre_part : ext_sum;
    end else begin
      remote = ext_sum + pre_part;
    end
    adj = (remote * 64'($signed(catch_r))) /
      64'($signed(ref_pkg::PCT_FULL));
    total = remote;
    if (din_catch_up && !din_slow_down) begin
      total = remote + adj;
    end else if (din_slow_down && !din_catch_up) begin
      total = remote - adj;
    end
    if (total > 64'($signed(rceil_r))) begin
      total = 64'($signed(rceil_r));
    end
    if (total < 64'($signed(rfloor_r))) begin
      total = 64'($signed(rfloor_r));
    end
    result_nxt = W'(total);
  end

  ////////////////////////////////////////////////////////////////////////
  // warning gate: stopped, ramping, live on reference
  assign at_ref = (out_freq == result_ref);
  always_comb begin
    wg_nxt = wg_r;
    case (wg_r)
      ref_pkg::WG_STOP: if (run_cmd) wg_nxt = ref_pkg::WG_RAMP;
      ref_pkg::WG_RAMP: begin
        if (!run_cmd) begin
          wg_nxt = ref_pkg::WG_STOP;
        end else if (at_ref) begin
          wg_nxt = ref_pkg::WG_LIVE;
        end
      end
      ref_pkg::WG_LIVE: if (!run_cmd) wg_nxt = ref_pkg::WG_STOP;
      default: wg_nxt = ref_pkg::WG_STOP;
    endcase
  end

  // comparators: low/high current, low/high frequency
  warn_cmp #(.HIGH_SIDE(1'b0)) u_wclow (.pclk(pclk), .presetn(presetn),
    .live(wg_r == ref_pkg::WG_LIVE), .value(out_current), .limit(clow_r),
    .warn(warns[0]));
  warn_cmp #(.HIGH_SIDE(1'b1)) u_wchigh (.pclk(pclk), .presetn(presetn),
    .live(wg_r == ref_pkg::WG_LIVE), .value(out_current), .limit(chigh_r),
    .warn(warns[1]));
  warn_cmp #(.HIGH_SIDE(1'b0)) u_wflow (.pclk(pclk), .presetn(presetn),
    .live(wg_r == ref_pkg::WG_LIVE), .value(out_freq), .limit(flow_r),
    .warn(warns[2]));
  warn_cmp #(.HIGH_SIDE(1'b1)) u_wfhigh (.pclk(pclk), .presetn(presetn),
    .live(wg_r == ref_pkg::WG_LIVE), .value(out_freq), .limit(freq_high_threshold_r),
    .warn(warns[3]));

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      catch_r <= ref_pkg::RST_CATCH;
      imax_r <= ref_pkg::RST_IMAXLIM;
      clow_r <= ref_pkg::RST_CLOW;
      chigh_r <= ref_pkg::RST_CHIGH;
      flow_r <= ref_pkg::RST_FLOW;
      freq_high_threshold_r <= ref_pkg::RST_FREQ_HIGH_THRESHOLD;
      rfloor_r <= ref_pkg::RST_RFLOOR;
      rceil_r <= ref_pkg::RST_RCEIL;
      route_r <= ref_pkg::RST_ROUTE[7:0];
      wg_r <= ref_pkg::WG_STOP;
      result_ref <= '0;
      prdata <= '0;
      pslverr <= 1'b0;
      pre_wait_r <= 1'b0;
      output_current_ceiling <= '0;
      warn_signal_out <= 1'b0;
      warn_relay_out <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      catch_r <= catch_nxt;
      imax_r <= imax_nxt;
      clow_r <= clow_nxt;
      chigh_r <= chigh_nxt;
      flow_r <= flow_nxt;
      freq_high_threshold_r <= freq_high_threshold_nxt;
      rfloor_r <= rfloor_nxt;
      rceil_r <= rceil_nxt;
      route_r <= route_nxt;
      wg_r <= wg_nxt;
      pre_wait_r <= pre_wait_nxt;
      result_ref <= result_nxt;
      // answer taken at setup; preset words one access cycle later
      prdata <= pre_wait_nxt ? preset_rd :
        ((psel && !penable) ? prdata_nxt : prdata);
      pslverr <= (psel && !penable) ? pslverr_nxt : 1'b0;
      output_current_ceiling <= W'(imax_r);
      warn_signal_out <= |(warns & route_r[3:0]);
      warn_relay_out <= |(warns & route_r[7:4]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_floor;
    @(posedge pclk) disable iff (!presetn)
    ($signed(rfloor_r) <= $signed(rceil_r)) && $stable(rfloor_r) &&
      $stable(rceil_r) |=> $signed(result_ref) >= $signed($past(rfloor_r));
  endproperty
  a_floor: assert property (p_floor) else $error("below floor");

  property p_ceil;
    @(posedge pclk) disable iff (!presetn)
    ($signed(rfloor_r) <= $signed(rceil_r)) && $stable(rfloor_r) &&
      $stable(rceil_r) |=> $signed(result_ref) <= $signed($past(rceil_r));
  endproperty
  a_ceil: assert property (p_ceil) else $error("above ceiling");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    (wg_r != ref_pkg::WG_LIVE) |=> (warns == '0);
  endproperty
  a_gate: assert property (p_gate) else $error("warn while gated");

  property p_quiet;
    @(posedge pclk) disable iff (!presetn)
    (!run_cmd) [*2] |=> (warns == '0);
  endproperty
  a_quiet: assert property (p_quiet) else $error("warn in stop");

  property p_live;
    @(posedge pclk) disable iff (!presetn)
    (wg_r == ref_pkg::WG_RAMP) && run_cmd && at_ref |=>
      (wg_r == ref_pkg::WG_LIVE);
  endproperty
  a_live: assert property (p_live) else $error("gate not opened");

  property p_flow;
    @(posedge pclk) disable iff (!presetn)
    flow_r <= freq_high_threshold_r;
  endproperty
  a_flow: assert property (p_flow) else $error("low freq over high");

  property p_clow;
    @(posedge pclk) disable iff (!presetn)
    (wg_r == ref_pkg::WG_LIVE) && (out_current < clow_r) |=> warns[0];
  endproperty
  a_clow: assert property (p_clow) else $error("low current missed");

  property p_chigh;
    @(posedge pclk) disable iff (!presetn)
    (wg_r == ref_pkg::WG_LIVE) && (out_current > chigh_r) |=> warns[1];
  endproperty
  a_chigh: assert property (p_chigh) else $error("high warn missed");

  property p_route;
    @(posedge pclk) disable iff (!presetn)
    (|(warns & route_r[3:0])) |=> warn_signal_out;
  endproperty
  a_route: assert property (p_route) else $error("route lost");
endmodule // ref_combiner

//--- verilog/ref_pkg.sv
// shared constants for the reference combiner and warning block
package ref_pkg;
  localparam int DW = 32;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PRESET0 = 12'h004;
  localparam logic [11:0] OFF_CATCH = 12'h014;
  localparam logic [11:0] OFF_CEIL = 12'h018;
  localparam logic [11:0] OFF_IMAXLIM = 12'h01c;
  localparam logic [11:0] OFF_CLOW = 12'h020;
  localparam logic [11:0] OFF_CHIGH = 12'h024;
  localparam logic [11:0] OFF_FLOW = 12'h028;
  localparam logic [11:0] OFF_FREQ_HIGH_THRESHOLD = 12'h02c;
  localparam logic [11:0] OFF_RFLOOR = 12'h030;
  localparam logic [11:0] OFF_RCEIL = 12'h034;
  localparam logic [11:0] OFF_ROUTE = 12'h038;
  localparam logic [11:0] OFF_STATUS = 12'h03c;
  localparam logic [11:0] OFF_RESULT = 12'h040;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_SERSEL = 4;
  // reset values, percentages in hundredths
  localparam logic [31:0] PCT_FULL = 32'h0000_2710; // 100.00 %
  localparam logic [31:0] PCT_NEG_FULL = 32'hffff_d8f0; // -100.00 %
  localparam logic [31:0] RST_PRESET = 32'h0;
  localparam logic [31:0] RST_CATCH = 32'h0;
  localparam logic [31:0] RST_IMAXLIM = 32'h0000_3e80; // 160.00 %
  localparam logic [31:0] RST_FLOW = 32'h0;
  localparam logic [31:0] RST_FREQ_HIGH_THRESHOLD = 32'h0000_0528; // 132.0 Hz
  localparam logic [31:0] RST_RFLOOR = 32'h0;
  localparam logic [31:0] RST_RCEIL = 32'h0000_01f4; // 50.0 Hz
  localparam logic [31:0] RST_CLOW = 32'h0;
  localparam logic [31:0] RST_CHIGH = 32'h7fff_ffff;
  localparam logic [31:0] RST_ROUTE = 32'h0;
  localparam int NWARN = 4;
  typedef enum logic [1:0] {
    MODE_SUM = 2'h0,
    MODE_REL = 2'h1,
    MODE_EXT = 2'h2
  } ref_mode_t;
  // warning gate states, gray along stop -> ramp -> on reference
  typedef enum logic [1:0] {
    WG_STOP = 2'h0,
    WG_RAMP = 2'h1,
    WG_LIVE = 2'h3
  } wgate_t;
endpackage

//--- verilog/warn_cmp.sv
// one threshold comparator producing a gated warning level
`timescale 1ns/1ps
module warn_cmp #(
  parameter bit HIGH_SIDE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic live,
  input wire logic [31:0] value,
  input wire logic [31:0] limit,
  output logic warn
);
  logic warn_nxt;

  ////////////////////////////////////////////////////////////////////////
  // compare; warnings only while evaluation is live
  always_comb begin
    if (HIGH_SIDE) begin
      warn_nxt = live && (value > limit);
    end else begin
      warn_nxt = live && (value < limit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn <= 1'b0;
    end else begin
      warn <= warn_nxt;
    end
  end
endmodule // warn_cmp
